/* File: core/pli_consts.svh */
`ifndef PLI_CONSTS_SVH
`define PLI_CONSTS_SVH

// Register indices; byte address is four times the index
`define PLI_IDX_LINK_CTRL 14'h0485
`define PLI_IDX_THRESH_CTRL 14'h0486
`define PLI_IDX_SLEEP_CTRL 14'h0487
`define PLI_IDX_ILV_CFG 14'h0489
`define PLI_IDX_STATUS 14'h048c

// Reset values
`define PLI_RST_LINK_CTRL 16'h1078
`define PLI_RST_THRESH_CTRL 16'h1405
`define PLI_RST_SLEEP_CTRL 16'h0a00
`define PLI_RST_ILV_CFG 16'h0001

// Writable bits of each register
`define PLI_WMASK_LINK_CTRL 16'hf1ff
`define PLI_WMASK_THRESH_CTRL 16'hffff
`define PLI_WMASK_SLEEP_CTRL 16'hffff
`define PLI_WMASK_ILV_CFG 16'h0007

// Link control fields
`define PLI_GAP_CHECK_DIS_BIT 13
`define PLI_LINK_ENABLE_BIT 12
`define PLI_LOCK_THR_MSB 8
`define PLI_LOCK_THR_LSB 0

// Threshold control fields
`define PLI_LOSS_THR_MSB 13
`define PLI_LOSS_THR_LSB 9
`define PLI_RR_THR_MSB 4
`define PLI_RR_THR_LSB 0

// Sleep signalling and interleave fields
`define PLI_SLEEP_EN_BIT 0
`define PLI_ILV_FORCE_BIT 2
`define PLI_ILV_ENABLE_BIT 1
`define PLI_ILV_DETECT_BIT 0

// Status register fields
`define PLI_ST_LINK_BIT 0
`define PLI_ST_RR_OK_BIT 1
`define PLI_ST_ILV_DET_BIT 2
`define PLI_ST_TX_ILV_BIT 3
`define PLI_ST_STATE_LSB 4
`define PLI_ST_ERR_LSB 8

`endif

/* File: core/pli_control.sv */
`timescale 1ns/1ps
`include "pli_consts.svh"

module pli_control
    import pli_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive symbol stream, one symbol per valid cycle
    input wire logic rx_sym_valid,
    input wire logic rx_sym_idle,
    input wire logic rx_sym_error,
    input wire logic rx_in_gap,
    input wire logic rx_interleave_seen,
    // Low-power-sleep code-groups
    input wire logic tx_sleep_request_signalling_req,
    input wire logic rx_sleep_request_signalling_seen,
    output logic tx_sleep_request_signalling,
    output logic rx_sleep_request_signalling,
    // PCS control outputs
    output logic training_enable,
    output logic link_up,
    output logic remote_rx_ok,
    output logic gap_lock_check_en,
    output logic sleep_signalling_en,
    output logic interleave_detect_en,
    output logic tx_interleave
);

    pli_core_type st_reg;
    pli_core_type st_next;

    logic ilv_detected;
    logic [8:0] lock_thr;
    logic [4:0] loss_thr;
    logic [4:0] rr_thr;
    logic link_en;
    logic gap_check_dis;
    logic check_now;
    logic [13:0] reg_idx;
    logic addr_ok;
    logic setup_phase;
    logic write_access;

    // Byte-lane merge of a 16-bit register, read-only bits kept
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0] strb,
        input logic [15:0] wmask
    );
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old_val & ~lanes) | (wdata[15:0] & lanes);
    endfunction

    // Saturating counters; a wrap would fake a fresh start
    function automatic logic [8:0] inc9(input logic [8:0] v);
        return (v == 9'h1ff) ? v : v + 9'h001;
    endfunction

    function automatic logic [4:0] inc5(input logic [4:0] v);
        return (v == 5'h1f) ? v : v + 5'h01;
    endfunction

    function automatic logic index_known(input logic [13:0] idx);
        return (idx == `PLI_IDX_LINK_CTRL) ||
            (idx == `PLI_IDX_THRESH_CTRL) ||
            (idx == `PLI_IDX_SLEEP_CTRL) ||
            (idx == `PLI_IDX_ILV_CFG) ||
            (idx == `PLI_IDX_STATUS);
    endfunction

    assign lock_thr =
        st_reg.link_ctrl_reg[`PLI_LOCK_THR_MSB:`PLI_LOCK_THR_LSB];
    assign loss_thr =
        st_reg.thresh_ctrl_reg[`PLI_LOSS_THR_MSB:`PLI_LOSS_THR_LSB];
    assign rr_thr =
        st_reg.thresh_ctrl_reg[`PLI_RR_THR_MSB:`PLI_RR_THR_LSB];
    assign link_en = st_reg.link_ctrl_reg[`PLI_LINK_ENABLE_BIT];
    assign gap_check_dis = st_reg.link_ctrl_reg[`PLI_GAP_CHECK_DIS_BIT];

    // Errors inside an inter-packet gap are ignored when disabled
    assign check_now = !(rx_in_gap && gap_check_dis);

    // Upper address bits beyond the index must be zero
    assign reg_idx = 14'(paddr >> 2);
    assign addr_ok = (paddr[1:0] == 2'b00) &&
        ((paddr >> 2) == ADDR_W'(reg_idx)) && index_known(reg_idx);
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite && addr_ok;

    always_comb begin
        st_next = st_reg;

        // Register writes take effect at the access edge
        if (write_access) begin
            unique case (reg_idx)
                `PLI_IDX_LINK_CTRL: begin
                    st_next.link_ctrl_reg = lane_merge(st_reg.link_ctrl_reg,
                        pwdata, pstrb, `PLI_WMASK_LINK_CTRL);
                end
                `PLI_IDX_THRESH_CTRL: begin
                    st_next.thresh_ctrl_reg = lane_merge(
                        st_reg.thresh_ctrl_reg, pwdata, pstrb,
                        `PLI_WMASK_THRESH_CTRL);
                end
                `PLI_IDX_SLEEP_CTRL: begin
                    st_next.sleep_ctrl_reg = lane_merge(
                        st_reg.sleep_ctrl_reg, pwdata, pstrb,
                        `PLI_WMASK_SLEEP_CTRL);
                end
                `PLI_IDX_ILV_CFG: begin
                    st_next.ilv_cfg_reg = lane_merge(st_reg.ilv_cfg_reg,
                        pwdata, pstrb, `PLI_WMASK_ILV_CFG);
                end
                default: begin
                    st_next.link_ctrl_reg = st_reg.link_ctrl_reg;
                end
            endcase
        end

        // Read data and error captured in setup, stable in access
        if (setup_phase) begin
            st_next.rdata_reg = 32'h0000_0000;
            st_next.slverr_reg = !addr_ok;
            if (!pwrite && addr_ok) begin
                unique case (reg_idx)
                    `PLI_IDX_LINK_CTRL: begin
                        st_next.rdata_reg[15:0] = st_reg.link_ctrl_reg;
                    end
                    `PLI_IDX_THRESH_CTRL: begin
                        st_next.rdata_reg[15:0] = st_reg.thresh_ctrl_reg;
                    end
                    `PLI_IDX_SLEEP_CTRL: begin
                        st_next.rdata_reg[15:0] = st_reg.sleep_ctrl_reg;
                    end
                    `PLI_IDX_ILV_CFG: begin
                        st_next.rdata_reg[15:0] = st_reg.ilv_cfg_reg;
                    end
                    default: begin
                        st_next.rdata_reg[`PLI_ST_LINK_BIT] =
                            (st_reg.state_reg == PLI_LOCKED);
                        st_next.rdata_reg[`PLI_ST_RR_OK_BIT] = remote_rx_ok;
                        st_next.rdata_reg[`PLI_ST_ILV_DET_BIT] = ilv_detected;
                        st_next.rdata_reg[`PLI_ST_TX_ILV_BIT] = tx_interleave;
                        st_next.rdata_reg[`PLI_ST_STATE_LSB +: 3] =
                            st_reg.state_reg;
                        st_next.rdata_reg[`PLI_ST_ERR_LSB +: 5] =
                            st_reg.err_cnt_reg;
                    end
                endcase
            end
        end

        // Sleep code-groups pass only with signalling enabled
        st_next.tx_sleep_reg = st_reg.sleep_ctrl_reg[`PLI_SLEEP_EN_BIT] &&
            tx_sleep_request_signalling_req;
        st_next.rx_sleep_reg = st_reg.sleep_ctrl_reg[`PLI_SLEEP_EN_BIT] &&
            rx_sleep_request_signalling_seen;

        // Lock acquisition and loss
        unique case (st_reg.state_reg)
            PLI_OFF: begin
                st_next.idle_cnt_reg = 9'h000;
                st_next.err_cnt_reg = 5'h00;
                st_next.rr_cnt_reg = 5'h00;
                st_next.rr_low_reg = 1'b0;
                if (link_en) begin
                    st_next.state_reg = PLI_ACQUIRE;
                end
            end
            PLI_ACQUIRE: begin
                if (!link_en) begin
                    st_next.state_reg = PLI_OFF;
                end else if (rx_sym_valid && rx_sym_idle) begin
                    st_next.idle_cnt_reg = inc9(st_reg.idle_cnt_reg);
                    if (inc9(st_reg.idle_cnt_reg) >= lock_thr) begin
                        st_next.state_reg = PLI_LOCKED;
                        st_next.idle_cnt_reg = 9'h000;
                        st_next.err_cnt_reg = 5'h00;
                        st_next.rr_cnt_reg = 5'h00;
                        st_next.rr_low_reg = 1'b0;
                    end
                end else if (rx_sym_valid && rx_sym_error && check_now) begin
                    // Idles must arrive as an unbroken run
                    st_next.idle_cnt_reg = 9'h000;
                end
            end
            PLI_LOCKED: begin
                if (!link_en) begin
                    st_next.state_reg = PLI_OFF;
                end else if (rx_sym_valid && rx_sym_error && check_now) begin
                    st_next.err_cnt_reg = inc5(st_reg.err_cnt_reg);
                    st_next.rr_cnt_reg = inc5(st_reg.rr_cnt_reg);
                    if (inc5(st_reg.rr_cnt_reg) >= rr_thr) begin
                        st_next.rr_low_reg = 1'b1;
                    end
                    if (inc5(st_reg.err_cnt_reg) >= loss_thr) begin
                        st_next.state_reg = PLI_ACQUIRE;
                        st_next.idle_cnt_reg = 9'h000;
                        st_next.err_cnt_reg = 5'h00;
                    end
                end else if (rx_sym_valid && rx_sym_idle) begin
                    // Error runs are broken by a clean idle
                    st_next.err_cnt_reg = 5'h00;
                    st_next.rr_cnt_reg = 5'h00;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.link_ctrl_reg <= `PLI_RST_LINK_CTRL;
            st_reg.thresh_ctrl_reg <= `PLI_RST_THRESH_CTRL;
            st_reg.sleep_ctrl_reg <= `PLI_RST_SLEEP_CTRL;
            st_reg.ilv_cfg_reg <= `PLI_RST_ILV_CFG;
            st_reg.state_reg <= PLI_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    pli_interleave u_interleave (
        .pclk(pclk),
        .presetn(presetn),
        .detect_en(st_reg.ilv_cfg_reg[`PLI_ILV_DETECT_BIT]),
        .ilv_en(st_reg.ilv_cfg_reg[`PLI_ILV_ENABLE_BIT]),
        .ilv_force(st_reg.ilv_cfg_reg[`PLI_ILV_FORCE_BIT]),
        .link_up(link_up),
        .rx_interleave_seen(rx_interleave_seen),
        .detected(ilv_detected),
        .tx_interleave(tx_interleave)
    );

    // Zero-wait slave: every access completes in one access cycle
    assign pready = psel && penable;
    assign prdata = st_reg.rdata_reg;
    assign pslverr = st_reg.slverr_reg && psel && penable;

    assign training_enable = link_en;
    assign link_up = (st_reg.state_reg == PLI_LOCKED);
    assign remote_rx_ok = link_up && !st_reg.rr_low_reg;
    assign gap_lock_check_en = !gap_check_dis;
    assign sleep_signalling_en = st_reg.sleep_ctrl_reg[`PLI_SLEEP_EN_BIT];
    assign interleave_detect_en = st_reg.ilv_cfg_reg[`PLI_ILV_DETECT_BIT];
    assign tx_sleep_request_signalling = st_reg.tx_sleep_reg;
    assign rx_sleep_request_signalling = st_reg.rx_sleep_reg;

endmodule

/* File: core/pli_interleave.sv */
`timescale 1ns/1ps
`include "pli_consts.svh"

module pli_interleave
    import pli_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire logic detect_en,
    input wire logic ilv_en,
    input wire logic ilv_force,
    input wire logic link_up,
    // Receive path indication
    input wire logic rx_interleave_seen,
    // Results
    output logic detected,
    output logic tx_interleave
);

    pli_ilv_type st_reg;
    pli_ilv_type st_next;

    always_comb begin
        st_next = st_reg;
        // Detection only while enabled; a dropped link forgets it
        st_next.detected_reg = detect_en & link_up &
            (st_reg.detected_reg | rx_interleave_seen);
        st_next.tx_ilv_reg = ilv_force |
            (ilv_en & st_reg.detected_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign detected = st_reg.detected_reg;
    assign tx_interleave = st_reg.tx_ilv_reg;

endmodule

/* File: core/pli_pkg.sv */
package pli_pkg;

    typedef enum logic [2:0] {
        PLI_OFF = 3'b001,
        PLI_ACQUIRE = 3'b010,
        PLI_LOCKED = 3'b100
    } pli_lock_state_type;

    typedef struct packed {
        logic [15:0] link_ctrl_reg;
        logic [15:0] thresh_ctrl_reg;
        logic [15:0] sleep_ctrl_reg;
        logic [15:0] ilv_cfg_reg;
        pli_lock_state_type state_reg;
        logic [8:0] idle_cnt_reg;
        logic [4:0] err_cnt_reg;
        logic [4:0] rr_cnt_reg;
        logic rr_low_reg;
        logic [31:0] rdata_reg;
        logic slverr_reg;
        logic tx_sleep_reg;
        logic rx_sleep_reg;
    } pli_core_type;

    typedef struct packed {
        logic detected_reg;
        logic tx_ilv_reg;
    } pli_ilv_type;

endpackage

/* File: sim/pli_control_asserts.sv */
`timescale 1ns/1ps
module pli_control_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Symbols
    input wire logic rx_sym_valid,
    input wire logic rx_sym_idle,
    input wire logic rx_sym_error,
    // Sleep signalling
    input wire logic sleep_signalling_en,
    input wire logic tx_sleep_request_signalling_req,
    input wire logic rx_sleep_request_signalling_seen,
    input wire logic tx_sleep_request_signalling,
    input wire logic rx_sleep_request_signalling,
    // Link state
    input wire logic training_enable,
    input wire logic link_up,
    input wire logic remote_rx_ok
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable;
    endsequence

    sequence s_off_twice;
        !training_enable [*2];
    endsequence

    AST_ZERO_WAIT: assert property (s_access |-> pready)
        else $error("access cycle without ready");
    AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access");
    AST_LOCK_ON_IDLE: assert property ($rose(link_up) |->
        $past(rx_sym_valid && rx_sym_idle))
        else $error("link rose without an idle symbol");
    AST_LOSS_ON_ERROR: assert property ($fell(link_up) |->
        $past(rx_sym_valid && rx_sym_error) || !training_enable)
        else $error("link fell without an error symbol");
    AST_OFF_HOLDS: assert property (s_off_twice |-> !link_up)
        else $error("link up while link control clear");
    AST_REMOTE_LOW: assert property ($fell(remote_rx_ok) |->
        $past(rx_sym_valid && rx_sym_error) || !link_up)
        else $error("remote status fell without error");
    AST_TX_SLEEP: assert property (tx_sleep_request_signalling |->
        $past(sleep_signalling_en && tx_sleep_request_signalling_req))
        else $error("sleep sent while disabled");
    AST_RX_SLEEP: assert property (sleep_signalling_en &&
        rx_sleep_request_signalling_seen |=> rx_sleep_request_signalling)
        else $error("sleep seen but not passed on");
endmodule

/* File: sim/pli_control_bench.sv */
`timescale 1ns/1ps
`include "pli_consts.svh"
module pli_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic tx_sleep_request_signalling_req = 1'b0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr;
    logic rx_sym_valid, rx_sym_idle, rx_sym_error, rx_in_gap;
    logic rx_interleave_seen, rx_sleep_request_signalling_seen;
    logic tx_sleep_request_signalling, rx_sleep_request_signalling;
    logic training_enable, link_up, remote_rx_ok, gap_lock_check_en;
    logic sleep_signalling_en, interleave_detect_en, tx_interleave;
    int errors = 0, tests_run = 0;
    logic [13:0] idx [4] = '{`PLI_IDX_LINK_CTRL, `PLI_IDX_THRESH_CTRL,
        `PLI_IDX_SLEEP_CTRL, `PLI_IDX_ILV_CFG};
    logic [15:0] sh [4] = '{16'h1078, 16'h1405, 16'h0a00, 16'h0001};
    logic [15:0] msk [4] = '{16'hf1ff, 16'hffff, 16'hffff, 16'h0007};
    // Each entry: expected transmit interleave, seen, configuration
    logic [4:0] itab [5] = '{5'b10100, 5'b00000, 5'b11011, 5'b01010,
        5'b01001};

    pli_control u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .rx_sym_valid, .rx_sym_idle,
        .rx_sym_error, .rx_in_gap, .rx_interleave_seen,
        .tx_sleep_request_signalling_req, .rx_sleep_request_signalling_seen,
        .tx_sleep_request_signalling, .rx_sleep_request_signalling,
        .training_enable, .link_up, .remote_rx_ok, .gap_lock_check_en,
        .sleep_signalling_en, .interleave_detect_en, .tx_interleave
    );

    pli_link_peer u_peer (
        .pclk, .rx_sym_valid, .rx_sym_idle, .rx_sym_error, .rx_in_gap,
        .rx_interleave_seen, .rx_sleep_request_signalling_seen
    );

    initial begin
        forever #4 pclk = ~pclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] o, d, m);
        return (o & ~m) | (d & m);
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [13:0] i,
        input logic [15:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            tally_and_finish();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Callers look only after the access edge's update has settled
        @(posedge pclk);
    endtask

    // Waits on the peer draining its burst, then lets the result settle
    task automatic sym(input logic k, input int n);
        int w;
        @(posedge pclk);
        u_peer.kind <= k;
        u_peer.cnt <= n;
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (u_peer.cnt != 0 && w < 300);
        if (w >= 300) begin
            errors++;
            tally_and_finish();
        end
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        logic [15:0] r;
        logic [1:0] j;
        r = 16'd49041;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk(training_enable, 1);
        chk(gap_lock_check_en, 1);
        chk(interleave_detect_en, 1);
        chk(sleep_signalling_en, 0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, idx[k], 16'h0000);
            chk(rdat, {16'h0000, sh[k]});
        end
        apb(1'b0, 14'h0488, 16'h0000);
        chk(rerr, 1);
        chk(rdat, 0);
        for (int k = 0; k < 8; k++) begin
            r = lfsr(r);
            j = r[1:0];
            pstrb <= {2'b11, r[3:2]};
            apb(1'b1, idx[j], r);
            pstrb <= 4'hf;
            sh[j] = merge(sh[j], r, msk[j] & {{8{r[3]}}, {8{r[2]}}});
            apb(1'b0, idx[j], 16'h0000);
            chk(rdat, {16'h0000, sh[j]});
        end
        // Lock after 3 idles, loss after 3 errors, remote low after 2
        apb(1'b1, idx[1], 16'h0602);
        apb(1'b1, idx[2], 16'h0a00);
        apb(1'b1, idx[3], 16'h0001);
        apb(1'b1, idx[0], 16'h1003);
        sym(1'b1, 2);
        sym(1'b0, 1);
        sym(1'b1, 2);
        chk(link_up, 0);
        sym(1'b1, 1);
        chk(link_up, 1);
        // Status: link and remote ok set, state locked, no errors
        apb(1'b0, `PLI_IDX_STATUS, 16'h0000);
        chk(rdat, 32'h0000_0043);
        chk(remote_rx_ok, 1);
        sym(1'b0, 1);
        chk(remote_rx_ok, 1);
        sym(1'b0, 1);
        chk(remote_rx_ok, 0);
        chk(link_up, 1);
        sym(1'b0, 1);
        chk(link_up, 0);
        sym(1'b1, 2);
        chk(link_up, 0);
        sym(1'b1, 1);
        chk(link_up, 1);
        chk(remote_rx_ok, 1);
        apb(1'b1, idx[0], 16'h3003);
        chk(gap_lock_check_en, 0);
        u_peer.gap <= 1'b1;
        sym(1'b0, 3);
        chk(link_up, 1);
        apb(1'b1, idx[0], 16'h1003);
        chk(gap_lock_check_en, 1);
        sym(1'b0, 3);
        chk(link_up, 0);
        u_peer.gap <= 1'b0;
        apb(1'b1, idx[0], 16'h0003);
        chk(training_enable, 0);
        sym(1'b1, 4);
        chk(link_up, 0);
        apb(1'b1, idx[0], 16'h1003);
        chk(training_enable, 1);
        sym(1'b1, 3);
        chk(link_up, 1);
        tx_sleep_request_signalling_req <= 1'b1;
        u_peer.slp <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, idx[2], {15'h0500, e[0]});
            repeat (2) @(posedge pclk);
            chk(sleep_signalling_en, e);
            chk(tx_sleep_request_signalling, e);
            chk(rx_sleep_request_signalling, e);
        end
        for (int k = 0; k < 5; k++) begin
            u_peer.ilv <= itab[k][3];
            apb(1'b1, idx[3], {13'h0000, itab[k][2:0]});
            repeat (4) @(posedge pclk);
            chk(interleave_detect_en, itab[k][0]);
            chk(tx_interleave, itab[k][4]);
        end
        tally_and_finish();
    end
endmodule

bind pli_control pli_control_asserts u_ast (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .rx_sym_valid,
    .rx_sym_idle, .rx_sym_error, .sleep_signalling_en,
    .tx_sleep_request_signalling_req, .rx_sleep_request_signalling_seen,
    .tx_sleep_request_signalling, .rx_sleep_request_signalling,
    .training_enable, .link_up, .remote_rx_ok
);

/* File: sim/pli_link_peer.sv */
`timescale 1ns/1ps
module pli_link_peer (
    // Clock
    input wire logic pclk,
    // Symbols toward the block
    output logic rx_sym_valid,
    output logic rx_sym_idle,
    output logic rx_sym_error,
    output logic rx_in_gap,
    // Line status
    output logic rx_interleave_seen,
    output logic rx_sleep_request_signalling_seen
);
    logic kind = 1'b1;
    logic gap = 1'b0;
    logic ilv = 1'b0;
    logic slp = 1'b0;
    int cnt = 0;

    assign rx_in_gap = gap;
    assign rx_interleave_seen = ilv;
    assign rx_sleep_request_signalling_seen = slp;

    initial begin
        rx_sym_valid = 1'b0;
        rx_sym_idle = 1'b0;
        rx_sym_error = 1'b1;
    end

    // Type lines toggle between symbols so stale values never count
    always @(posedge pclk) begin
        if (cnt != 0) begin
            rx_sym_valid <= 1'b1;
            rx_sym_idle <= kind;
            rx_sym_error <= !kind;
            cnt <= cnt - 1;
        end else begin
            rx_sym_valid <= 1'b0;
            rx_sym_idle <= !rx_sym_idle;
            rx_sym_error <= rx_sym_idle;
        end
    end
endmodule
